// [ssr_status_bank.sv]
// Status subsystem: eleven register sets, IEEE status registers and error queue
//
// Functional notes
// - Condition query returns current bits 0..14 and leaves them unchanged.
// - Event query returns latched bits, then clears that event register.
// - Access naming no register of a group acts as an event query.
// - Enable mask write stores low 15 bits; bit 15 stays zero.
// - Falling filter write stores low 15 bits; bit 15 stays zero.
// - Rising filter write stores low 15 bits; bit 15 held at zero.
// - Enable mask read returns stored 15-bit value.
// - Falling filter read returns stored 15-bit value.
// - Filters and masks preset at power-on and status preset only.
// - Event registers cleared by event query, clear-status and power-on only.
// - Queue enable preset at power-on/preset; queue emptied by clear-status/power-on.
// - Standard event enable and service request enable cleared only at power-on.
// - Standard event status and status byte cleared by clear-status and power-on.
// - Group number selects which register set a command reaches.
// - Event bit latches on filtered falling or rising condition edge.
`timescale 1ns/10ps
module ssr_status_bank #(
    parameter int QDEPTH = ssr_pkg::QUEUE_DEPTH
) (
    // Clock and power-on reset
    input wire logic ref_clk,
    input wire logic reset,
    // Command from the controller
    input wire logic cmd_valid,
    input wire logic [3:0] cmd_group,
    input wire logic [3:0] cmd_op,
    input wire logic [15:0] cmd_wdata,
    // Response to the controller
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic rsp_bad_group,
    // Common status events
    input wire logic clear_status,
    input wire logic status_preset,
    // Status sources
    input wire logic [15:0] cond_in [ssr_pkg::GROUPS],
    input wire logic [7:0] std_event_set,
    input wire logic err_push,
    input wire logic [15:0] err_code,
    // Status outputs
    output logic [ssr_pkg::GROUPS-1:0] group_summary,
    output logic [7:0] status_byte,
    output logic service_request
);
    localparam int GW = ssr_pkg::GRP_W;

    // Per-group state
    logic [15:0] grp_cond [ssr_pkg::GROUPS];
    logic [15:0] grp_event [ssr_pkg::GROUPS];
    logic [15:0] grp_mask [ssr_pkg::GROUPS];
    logic [15:0] grp_ntr [ssr_pkg::GROUPS];
    logic [15:0] grp_ptr [ssr_pkg::GROUPS];
    logic [ssr_pkg::GROUPS-1:0] grp_sum;

    // Decode
    ssr_pkg::ssr_op_t op_kind;
    logic known_op, grp_ok, set_op;
    logic [15:0] sel_cond, sel_event, sel_mask, sel_ntr, sel_ptr;

    // IEEE registers, queue enable and response
    logic [7:0] ese_ff, nxt_ese, sre_ff, nxt_sre;
    logic [7:0] sesr_ff, nxt_sesr, stb_ff, nxt_stb;
    logic qen_ff, nxt_qen;
    logic rsp_valid_ff, nxt_rsp_valid, rsp_bad_ff, nxt_rsp_bad;
    logic [15:0] rsp_data_ff, nxt_rsp_data;

    // Queue
    logic [15:0] q_head;
    logic q_empty, q_pop, q_push;

    // Command code decode; unknown codes fall back to an event query
    always_comb begin
        op_kind = ssr_pkg::OP_EVENT_RD;
        known_op = 1'b1;
        case (cmd_op)
            ssr_pkg::OP_COND_RD: op_kind = ssr_pkg::OP_COND_RD;
            ssr_pkg::OP_EN_WR: op_kind = ssr_pkg::OP_EN_WR;
            ssr_pkg::OP_EN_RD: op_kind = ssr_pkg::OP_EN_RD;
            ssr_pkg::OP_NTR_WR: op_kind = ssr_pkg::OP_NTR_WR;
            ssr_pkg::OP_NTR_RD: op_kind = ssr_pkg::OP_NTR_RD;
            ssr_pkg::OP_PTR_WR: op_kind = ssr_pkg::OP_PTR_WR;
            ssr_pkg::OP_PTR_RD: op_kind = ssr_pkg::OP_PTR_RD;
            ssr_pkg::OP_ESE_WR: op_kind = ssr_pkg::OP_ESE_WR;
            ssr_pkg::OP_ESE_RD: op_kind = ssr_pkg::OP_ESE_RD;
            ssr_pkg::OP_SRE_WR: op_kind = ssr_pkg::OP_SRE_WR;
            ssr_pkg::OP_SRE_RD: op_kind = ssr_pkg::OP_SRE_RD;
            ssr_pkg::OP_SESR_RD: op_kind = ssr_pkg::OP_SESR_RD;
            ssr_pkg::OP_STB_RD: op_kind = ssr_pkg::OP_STB_RD;
            ssr_pkg::OP_QEN_WR: op_kind = ssr_pkg::OP_QEN_WR;
            ssr_pkg::OP_QUEUE_RD: op_kind = ssr_pkg::OP_QUEUE_RD;
            ssr_pkg::OP_EVENT_RD: op_kind = ssr_pkg::OP_EVENT_RD;
            default: begin
                op_kind = ssr_pkg::OP_EVENT_RD;
                known_op = 1'b0;
            end
        endcase
        // Only register set commands need a group number
        set_op = (op_kind <= ssr_pkg::OP_PTR_RD);
        grp_ok = (cmd_group < ssr_pkg::GROUP_COUNT);
    end

    // Selected group's registers; an out-of-range group reads zero
    always_comb begin
        sel_cond = ssr_pkg::ZERO16;
        sel_event = ssr_pkg::ZERO16;
        sel_mask = ssr_pkg::ZERO16;
        sel_ntr = ssr_pkg::ZERO16;
        sel_ptr = ssr_pkg::ZERO16;
        if (grp_ok) begin
            sel_cond = grp_cond[cmd_group];
            sel_event = grp_event[cmd_group];
            sel_mask = grp_mask[cmd_group];
            sel_ntr = grp_ntr[cmd_group];
            sel_ptr = grp_ptr[cmd_group];
        end
    end

    // One register set per status group, each steered by its own strobes
    for (genvar g = 0; g < ssr_pkg::GROUPS; g++) begin : g_set
        logic hit;
        assign hit = cmd_valid && grp_ok && (cmd_group == GW'(g));
        ssr_reg_set u_set (
            .ref_clk(ref_clk),
            .reset(reset),
            .cond_in(cond_in[g]),
            .wr_mask(hit && op_kind == ssr_pkg::OP_EN_WR),
            .wr_ntr(hit && op_kind == ssr_pkg::OP_NTR_WR),
            .wr_ptr(hit && op_kind == ssr_pkg::OP_PTR_WR),
            .wdata(cmd_wdata),
            .evt_read(hit && op_kind == ssr_pkg::OP_EVENT_RD),
            .clear_status(clear_status),
            .status_preset(status_preset),
            .cond_q(grp_cond[g]),
            .event_q(grp_event[g]),
            .mask_q(grp_mask[g]),
            .ntr_q(grp_ntr[g]),
            .ptr_q(grp_ptr[g]),
            .summary_q(grp_sum[g])
        );
    end

    // Queue fills only while enabled; a read drains one entry
    assign q_push = err_push && qen_ff;
    assign q_pop = cmd_valid && op_kind == ssr_pkg::OP_QUEUE_RD;

    ssr_err_queue #(
        .WIDTH(ssr_pkg::REG_W),
        .DEPTH(QDEPTH)
    ) u_queue (
        .ref_clk(ref_clk),
        .reset(reset),
        .push(q_push),
        .push_data(err_code),
        .pop(q_pop),
        .clear(clear_status),
        .head(q_head),
        .empty(q_empty),
        .full()
    );

    // IEEE status registers and queue enable
    always_comb begin
        nxt_ese = ese_ff;
        nxt_sre = sre_ff;
        nxt_qen = qen_ff;
        // Event and request enables are never touched by clear-status or preset; preset loads the queue enable
        if (cmd_valid && op_kind == ssr_pkg::OP_ESE_WR) nxt_ese = cmd_wdata[7:0];
        if (cmd_valid && op_kind == ssr_pkg::OP_SRE_WR) nxt_sre = cmd_wdata[7:0];
        if (status_preset) begin
            nxt_qen = ssr_pkg::QEN_PRESET;
        end else if (cmd_valid && op_kind == ssr_pkg::OP_QEN_WR) begin
            nxt_qen = cmd_wdata[0];
        end
        // Reading the event status register empties it; new events still land
        nxt_sesr = sesr_ff;
        if (clear_status || (cmd_valid && op_kind == ssr_pkg::OP_SESR_RD)) begin
            nxt_sesr = ssr_pkg::ZERO8;
        end
        nxt_sesr = nxt_sesr | std_event_set;
        // Status byte gathers summaries; rebuilt every cycle
        nxt_stb = ssr_pkg::ZERO8;
        nxt_stb[ssr_pkg::STB_QUEUE_BIT] = !q_empty;
        nxt_stb[ssr_pkg::STB_QUES_BIT] = grp_sum[ssr_pkg::GRP_QUES];
        nxt_stb[ssr_pkg::STB_ESB_BIT] = |(sesr_ff & ese_ff);
        nxt_stb[ssr_pkg::STB_OPER_BIT] = grp_sum[ssr_pkg::GRP_OPER];
        nxt_stb[ssr_pkg::STB_RQS_BIT] = |(nxt_stb & sre_ff);
        if (clear_status) nxt_stb = ssr_pkg::ZERO8;
    end

    // Power-on clears the IEEE registers and presets the queue enable
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ese_ff <= ssr_pkg::ZERO8;
            sre_ff <= ssr_pkg::ZERO8;
            sesr_ff <= ssr_pkg::ZERO8;
            stb_ff <= ssr_pkg::ZERO8;
            qen_ff <= ssr_pkg::QEN_PRESET;
        end else begin
            ese_ff <= nxt_ese;
            sre_ff <= nxt_sre;
            sesr_ff <= nxt_sesr;
            stb_ff <= nxt_stb;
            qen_ff <= nxt_qen;
        end
    end

    // Response for every accepted command, one edge later
    always_comb begin
        nxt_rsp_valid = cmd_valid;
        nxt_rsp_bad = cmd_valid && set_op && !grp_ok;
        nxt_rsp_data = rsp_data_ff;
        if (cmd_valid) begin
            case (op_kind)
                ssr_pkg::OP_COND_RD: nxt_rsp_data = ssr_pkg::ssr_low15(sel_cond);
                ssr_pkg::OP_EN_RD: nxt_rsp_data = ssr_pkg::ssr_low15(sel_mask);
                ssr_pkg::OP_NTR_RD: nxt_rsp_data = ssr_pkg::ssr_low15(sel_ntr);
                ssr_pkg::OP_PTR_RD: nxt_rsp_data = ssr_pkg::ssr_low15(sel_ptr);
                ssr_pkg::OP_EVENT_RD: nxt_rsp_data = ssr_pkg::ssr_low15(sel_event);
                ssr_pkg::OP_ESE_RD: nxt_rsp_data = {ssr_pkg::ZERO8, ese_ff};
                ssr_pkg::OP_SRE_RD: nxt_rsp_data = {ssr_pkg::ZERO8, sre_ff};
                ssr_pkg::OP_SESR_RD: nxt_rsp_data = {ssr_pkg::ZERO8, sesr_ff};
                ssr_pkg::OP_STB_RD: nxt_rsp_data = {ssr_pkg::ZERO8, stb_ff};
                // Empty queue answers zero, the no-error code
                ssr_pkg::OP_QUEUE_RD: nxt_rsp_data = q_empty ? ssr_pkg::ZERO16 : q_head;
                default: nxt_rsp_data = ssr_pkg::ZERO16; // Writes answer zero
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rsp_valid_ff <= 1'b0;
            rsp_bad_ff <= 1'b0;
            rsp_data_ff <= ssr_pkg::ZERO16;
        end else begin
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_bad_ff <= nxt_rsp_bad;
            rsp_data_ff <= nxt_rsp_data;
        end
    end

    // Outputs
    assign rsp_valid = rsp_valid_ff;
    assign rsp_data = rsp_data_ff;
    assign rsp_bad_group = rsp_bad_ff;
    assign group_summary = grp_sum;
    assign status_byte = stb_ff;
    assign service_request = stb_ff[ssr_pkg::STB_RQS_BIT];

    rsp_timing_a: assert property (@(posedge ref_clk) disable iff (reset)
        cmd_valid |=> rsp_valid_ff ##1 (rsp_valid_ff == $past(cmd_valid)))
        else $error("response not one cycle after command");
    group_route_a: assert property (@(posedge ref_clk) disable iff (reset)
        cmd_valid && set_op && !grp_ok |=> rsp_bad_ff && rsp_data_ff[15] == 1'b0)
        else $error("bad group not flagged");
    cond_read_a: assert property (@(posedge ref_clk) disable iff (reset)
        cmd_valid && grp_ok && op_kind == ssr_pkg::OP_COND_RD
        |=> rsp_data_ff == ssr_pkg::ssr_low15($past(sel_cond)) && !rsp_bad_ff)
        else $error("condition read wrong");
    default_op_a: assert property (@(posedge ref_clk) disable iff (reset)
        cmd_valid && grp_ok && (!known_op || op_kind == ssr_pkg::OP_EVENT_RD)
        |=> rsp_data_ff == ssr_pkg::ssr_low15($past(sel_event)))
        else $error("unknown code not an event query");
    enable_read_a: assert property (@(posedge ref_clk) disable iff (reset)
        cmd_valid && grp_ok && op_kind == ssr_pkg::OP_EN_RD
        |=> rsp_data_ff == $past(sel_mask) && !rsp_data_ff[15])
        else $error("enable read wrong");
    ntr_read_a: assert property (@(posedge ref_clk) disable iff (reset)
        cmd_valid && grp_ok && op_kind == ssr_pkg::OP_NTR_RD
        |=> rsp_data_ff == $past(sel_ntr) && !rsp_data_ff[15])
        else $error("falling filter read wrong");
    ese_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
        !(cmd_valid && op_kind == ssr_pkg::OP_ESE_WR) |=> ese_ff == $past(ese_ff))
        else $error("event enable changed without write");
    sesr_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
        clear_status && std_event_set == ssr_pkg::ZERO8
        |=> sesr_ff == ssr_pkg::ZERO8 && stb_ff == ssr_pkg::ZERO8)
        else $error("clear status left standard status");
    queue_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
        clear_status && !err_push |=> q_empty)
        else $error("clear status left queue entries");
endmodule // ssr_status_bank

// [ssr_pkg.sv]
// Shared constants, command codes and helpers for the status register bank
package ssr_pkg;
    // Widths and sizes
    localparam int GROUPS = 11;
    localparam int REG_W = 16;
    localparam int GRP_W = 4;
    localparam int OP_W = 4;
    localparam int BYTE_W = 8;
    localparam int QUEUE_DEPTH = 8;
    localparam logic [3:0] GROUP_COUNT = 4'hb;

    // Field masks and preset values
    localparam logic [15:0] LOW15_MASK = 16'h7fff;
    localparam logic [15:0] PTR_PRESET = 16'h7fff;
    localparam logic [15:0] NTR_PRESET = 16'h0000;
    localparam logic [15:0] EN_PRESET = 16'h0000;
    localparam logic [15:0] ZERO16 = 16'h0000;
    localparam logic [7:0] ZERO8 = 8'h00;
    localparam logic QEN_PRESET = 1'b1;

    // Status group indices
    localparam logic [3:0] GRP_DEV = 4'h0;
    localparam logic [3:0] GRP_OPER = 4'h1;
    localparam logic [3:0] GRP_QUES = 4'h8;

    // Status byte bit positions
    localparam int STB_QUEUE_BIT = 2;
    localparam int STB_QUES_BIT = 3;
    localparam int STB_ESB_BIT = 5;
    localparam int STB_RQS_BIT = 6;
    localparam int STB_OPER_BIT = 7;

    // Command codes; any other code acts as an event query
    typedef enum logic [3:0] {
        OP_EVENT_RD = 4'h0,
        OP_COND_RD = 4'h1,
        OP_EN_WR = 4'h2,
        OP_EN_RD = 4'h3,
        OP_NTR_WR = 4'h4,
        OP_NTR_RD = 4'h5,
        OP_PTR_WR = 4'h6,
        OP_PTR_RD = 4'h7,
        OP_ESE_WR = 4'h8,
        OP_ESE_RD = 4'h9,
        OP_SRE_WR = 4'ha,
        OP_SRE_RD = 4'hb,
        OP_SESR_RD = 4'hc,
        OP_STB_RD = 4'hd,
        OP_QEN_WR = 4'he,
        OP_QUEUE_RD = 4'hf
    } ssr_op_t;

    // Keep the low 15 bits, bit 15 forced to zero
    function automatic logic [15:0] ssr_low15(input logic [15:0] v);
        return v & LOW15_MASK;
    endfunction
endpackage

// [ssr_reg_set.sv]
// One status register set: condition, transition filters, event and enable mask
`timescale 1ns/10ps
module ssr_reg_set #(
    parameter logic [15:0] PTR_INIT = ssr_pkg::PTR_PRESET,
    parameter logic [15:0] NTR_INIT = ssr_pkg::NTR_PRESET,
    parameter logic [15:0] EN_INIT = ssr_pkg::EN_PRESET
) (
    // Clock and power-on reset
    input wire logic ref_clk,
    input wire logic reset,
    // Live condition bits
    input wire logic [15:0] cond_in,
    // Register writes
    input wire logic wr_mask,
    input wire logic wr_ntr,
    input wire logic wr_ptr,
    input wire logic [15:0] wdata,
    // Event controls
    input wire logic evt_read,
    input wire logic clear_status,
    input wire logic status_preset,
    // Register state
    output logic [15:0] cond_q,
    output logic [15:0] event_q,
    output logic [15:0] mask_q,
    output logic [15:0] ntr_q,
    output logic [15:0] ptr_q,
    output logic summary_q
);
    logic [15:0] cond_ff, nxt_cond, event_ff, nxt_event;
    logic [15:0] mask_ff, nxt_mask, ntr_ff, nxt_ntr, ptr_ff, nxt_ptr;
    logic summary_ff, nxt_summary;
    logic [15:0] rise, fall, hits;

    // Edge filtering, sticky events, filter and mask updates
    always_comb begin
        rise = cond_in & ~cond_ff;
        fall = ~cond_in & cond_ff;
        hits = ssr_pkg::ssr_low15((rise & ptr_ff) | (fall & ntr_ff));
        nxt_cond = ssr_pkg::ssr_low15(cond_in);
        nxt_event = event_ff;
        if (evt_read || clear_status) begin
            nxt_event = ssr_pkg::ZERO16;
        end
        nxt_event = nxt_event | hits; // New edge beats the clear
        nxt_mask = mask_ff;
        nxt_ntr = ntr_ff;
        nxt_ptr = ptr_ff;
        if (status_preset) begin
            nxt_mask = EN_INIT;
            nxt_ntr = NTR_INIT;
            nxt_ptr = PTR_INIT;
        end else begin
            if (wr_mask) nxt_mask = ssr_pkg::ssr_low15(wdata);
            if (wr_ntr) nxt_ntr = ssr_pkg::ssr_low15(wdata);
            if (wr_ptr) nxt_ptr = ssr_pkg::ssr_low15(wdata);
        end
        // Built from next values so it lines up with the event register
        nxt_summary = |(nxt_event & nxt_mask);
    end

    // Power-on clears events and presets filters and mask
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cond_ff <= ssr_pkg::ZERO16;
            event_ff <= ssr_pkg::ZERO16;
            mask_ff <= EN_INIT;
            ntr_ff <= NTR_INIT;
            ptr_ff <= PTR_INIT;
            summary_ff <= 1'b0;
        end else begin
            cond_ff <= nxt_cond;
            event_ff <= nxt_event;
            mask_ff <= nxt_mask;
            ntr_ff <= nxt_ntr;
            ptr_ff <= nxt_ptr;
            summary_ff <= nxt_summary;
        end
    end

    assign cond_q = cond_ff;
    assign event_q = event_ff;
    assign mask_q = mask_ff;
    assign ntr_q = ntr_ff;
    assign ptr_q = ptr_ff;
    assign summary_q = summary_ff;

    mask_write_a: assert property (@(posedge ref_clk) disable iff (reset)
        wr_mask && !status_preset |=> mask_ff == ssr_pkg::ssr_low15($past(wdata)))
        else $error("enable mask write wrong");
    ntr_write_a: assert property (@(posedge ref_clk) disable iff (reset)
        wr_ntr && !status_preset |=> ntr_ff == ssr_pkg::ssr_low15($past(wdata)))
        else $error("falling filter write wrong");
    ptr_write_a: assert property (@(posedge ref_clk) disable iff (reset)
        wr_ptr && !status_preset |=> ptr_ff == ssr_pkg::ssr_low15($past(wdata)))
        else $error("rising filter write wrong");
    event_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
        evt_read && hits == ssr_pkg::ZERO16 |=> event_ff == ssr_pkg::ZERO16)
        else $error("event query did not clear");
    cls_clear_a: assert property (@(posedge ref_clk) disable iff (reset)
        clear_status && hits == ssr_pkg::ZERO16 |=> event_ff == ssr_pkg::ZERO16)
        else $error("clear status left events");
    edge_latch_a: assert property (@(posedge ref_clk) disable iff (reset)
        (cond_in[0] && !cond_ff[0] && ptr_ff[0]) |=> event_ff[0] ##1 event_ff[0] || evt_read
        || clear_status || $past(evt_read) || $past(clear_status))
        else $error("rising edge not latched");
    event_sticky_a: assert property (@(posedge ref_clk) disable iff (reset)
        !evt_read && !clear_status |=> (event_ff & $past(event_ff)) == $past(event_ff))
        else $error("event bit dropped");
    preset_value_a: assert property (@(posedge ref_clk) disable iff (reset)
        status_preset |=> ptr_ff == PTR_INIT && ntr_ff == NTR_INIT && mask_ff == EN_INIT)
        else $error("status preset wrong");
endmodule // ssr_reg_set

// [ssr_err_queue.sv]
// Error and event queue with clear, drop on full
`timescale 1ns/10ps
module ssr_err_queue #(
    parameter int WIDTH = ssr_pkg::REG_W,
    parameter int DEPTH = ssr_pkg::QUEUE_DEPTH
) (
    // Clock and power-on reset
    input wire logic ref_clk,
    input wire logic reset,
    // Fill and drain
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    input wire logic pop,
    input wire logic clear,
    // State
    output logic [WIDTH-1:0] head,
    output logic empty,
    output logic full
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [WIDTH-1:0] nxt_mem [DEPTH];
    logic [AW-1:0] rd_ff, nxt_rd, wr_ff, nxt_wr;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic do_push, do_pop;

    function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
        return (p == LAST_PTR) ? '0 : p + 1'b1;
    endfunction

    // A push in the clearing cycle survives as the only entry
    always_comb begin
        nxt_mem = mem_ff;
        do_pop = pop && !empty && !clear;
        do_push = push && (clear || !full);
        nxt_rd = clear ? '0 : (do_pop ? step(rd_ff) : rd_ff);
        nxt_wr = clear ? '0 : wr_ff;
        nxt_cnt = clear ? '0 : (do_pop ? cnt_ff - 1'b1 : cnt_ff);
        if (do_push) begin
            nxt_mem[nxt_wr] = push_data;
            nxt_wr = step(nxt_wr);
            nxt_cnt = nxt_cnt + 1'b1;
        end
    end

    // Storage holds no reset; only pointers and count need one
    always_ff @(posedge ref_clk) begin
        mem_ff <= nxt_mem;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_ff <= '0;
            wr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            rd_ff <= nxt_rd;
            wr_ff <= nxt_wr;
            cnt_ff <= nxt_cnt;
        end
    end

    assign head = mem_ff[rd_ff];
    assign empty = (cnt_ff == '0);
    assign full = (cnt_ff == FULL_CNT);
endmodule // ssr_err_queue

// [ssr_ctrl_model.sv]
// Controller model that issues status commands to the bank
`timescale 1ns/10ps
module ssr_ctrl_model (
    // Command lines toward the bank
    output logic cmd_valid,
    output logic [3:0] cmd_group,
    output logic [3:0] cmd_op,
    output logic [15:0] cmd_wdata
);
    // Idle at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_group = 4'h0;
        cmd_op = 4'h0;
        cmd_wdata = 16'h0000;
    end
    // Group prefix picks the target set
    task automatic put(input logic [3:0] g, input logic [3:0] op, input logic [15:0] wd);
        cmd_valid = 1'b1;
        cmd_group = g;
        cmd_op = op;
        cmd_wdata = wd;
    endtask
    // Released group and data lines carry inverted junk; the op code keeps its old value
    task automatic drop();
        cmd_valid = 1'b0;
        cmd_group = ~cmd_group;
        cmd_wdata = ~cmd_wdata;
    endtask
endmodule // ssr_ctrl_model

// [tb.sv]
// Random command traffic against an integer model of the status bank
`timescale 1ns/10ps
module tb;
    logic ref_clk, reset, clear_status, status_preset;
    logic cmd_valid, rsp_valid, rsp_bad_group, service_request;
    logic [3:0] cmd_group, cmd_op;
    logic [15:0] cmd_wdata, rsp_data;
    logic [15:0] cond [ssr_pkg::GROUPS];
    logic [10:0] group_summary, xs;
    logic [7:0] status_byte;
    logic xv, xb, hit, err_push;
    logic [7:0] std_set;
    logic [15:0] err_code;
    integer ev[11], en[11], nt[11], pt[11], cq[11];
    integer xd, c, nv, w, k, j, errors, checked, seed, r;
    integer ese, sre, sesr, stb, qen, pf, st;
    integer q[$];

    ssr_ctrl_model i_ctrl (.cmd_valid(cmd_valid), .cmd_group(cmd_group), .cmd_op(cmd_op),
        .cmd_wdata(cmd_wdata));
    ssr_status_bank i_dut (.ref_clk(ref_clk), .reset(reset), .cmd_valid(cmd_valid),
        .cmd_group(cmd_group), .cmd_op(cmd_op), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_bad_group(rsp_bad_group),
        .clear_status(clear_status), .status_preset(status_preset), .cond_in(cond),
        .std_event_set(std_set), .err_push(err_push), .err_code(err_code),
        .group_summary(group_summary), .status_byte(status_byte),
        .service_request(service_request));

    always #2.5 ref_clk = ~ref_clk;

    // Model state moves on the same edge as the design
    always @(posedge ref_clk) begin
        xv = !reset && cmd_valid;
        xb = xv && cmd_group > 4'ha && cmd_op < 4'h8;
        w = cmd_wdata & 16'h7fff;
        if (xv) xd = 0;
        // IEEE side from old state; status byte sees the old summaries
        if (xv && cmd_op > 7) xd = cmd_op == 9 ? ese : cmd_op == 11 ? sre : cmd_op == 12 ? sesr
            : cmd_op == 13 ? stb : cmd_op == 15 && q.size() > 0 ? q[0] : 0;
        st = (q.size() > 0 ? 4 : 0) | (xs[8] ? 8 : 0) | ((sesr & ese) != 0 ? 32 : 0);
        st = st | (xs[1] ? 128 : 0);
        st = st | ((st & sre) != 0 ? 64 : 0);
        stb = clear_status ? 0 : st;
        sesr = ((clear_status || (xv && cmd_op == 12)) ? 0 : sesr) | std_set;
        // Full is judged before the pop, and a clear lets the push in
        pf = err_push && qen && (clear_status || q.size() < ssr_pkg::QUEUE_DEPTH);
        if (xv && cmd_op == 15 && q.size() > 0) void'(q.pop_front());
        if (clear_status) q.delete();
        if (pf) q.push_back(err_code);
        if (xv && cmd_op == 8) ese = cmd_wdata & 255;
        if (xv && cmd_op == 10) sre = cmd_wdata & 255;
        if (xv && cmd_op == 14) qen = cmd_wdata & 1;
        if (status_preset) qen = 1;
        for (k = 0; k < 11; k++) begin
            hit = xv && !xb && cmd_group == k;
            c = cond[k] & 16'h7fff;
            nv = (c & ~cq[k] & pt[k]) | (~c & cq[k] & nt[k]);
            if (hit && cmd_op < 8) xd = cmd_op == 0 ? ev[k] : cmd_op == 1 ? cq[k]
                : cmd_op == 3 ? en[k]
                : cmd_op == 5 ? nt[k] : cmd_op == 7 ? pt[k] : 0;
            ev[k] = ((hit && cmd_op == 0) || clear_status ? 0 : ev[k]) | nv;
            cq[k] = c;
            if (hit && cmd_op == 2) en[k] = w;
            if (hit && cmd_op == 4) nt[k] = w;
            if (hit && cmd_op == 6) pt[k] = w;
            // Preset beats a write in the same cycle
            if (status_preset || reset) begin
                en[k] = 0;
                nt[k] = 0;
                pt[k] = 32'h7fff;
            end
            if (reset) ev[k] = 0;
            if (reset) cq[k] = 0;
            xs[k] = (ev[k] & en[k]) != 0;
        end
        if (reset) begin
            xd = 0;
            ese = 0;
            sre = 0;
            sesr = 0;
            stb = 0;
            qen = 1;
            q.delete();
        end
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_all();
        chk("rsp_valid", 16'(xv), 16'(rsp_valid));
        if (xv) chk("rsp_data", xd[15:0], rsp_data);
        if (xv) chk("rsp_bad_group", 16'(xb), 16'(rsp_bad_group));
        chk("group_summary", 16'(xs), 16'(group_summary));
        chk("status_byte", 16'(stb), 16'(status_byte));
        chk("service_request", 16'(stb[6]), 16'(service_request));
    endtask

    task automatic print_verdict();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Conditions move only in idle cycles, so a query sees settled bits
    initial begin
        errors = 0;
        checked = 0;
        seed = 32'h0fba;
        ref_clk = 1'b0;
        reset = 1'b1;
        clear_status = 1'b0;
        status_preset = 1'b0;
        std_set = 8'h00;
        err_push = 1'b0;
        err_code = 16'h0000;
        for (j = 0; j < 11; j++) cond[j] = 16'h0000;
        repeat (12) @(negedge ref_clk);
        reset = 1'b0;
        repeat (4000) begin
            @(negedge ref_clk);
            check_all();
            r = $random(seed);
            clear_status = r[5:0] == 6'h00;
            status_preset = r[13:8] == 6'h00;
            // Sparse standard events and a busy queue that reaches full
            std_set = r[7:6] == 2'h0 ? 8'h01 << r[30:28] : 8'h00;
            err_push = r[27:26] == 2'h0;
            err_code = 16'($random(seed));
            if (r[17:16] == 2'h0) begin
                for (j = 0; j < 11; j++) cond[j] = 16'($random(seed));
                i_ctrl.drop();
            end else begin
                i_ctrl.put(r[21:18], r[25:22], 16'($random(seed)));
            end
        end
        print_verdict();
    end

    // Hang guard
    initial begin
        #50000;
        errors++;
        print_verdict();
    end
endmodule // tb
